/* hdl/reset_standby_frame_sync.sv */
`timescale 1ns/1ps
// top of the reset, standby and frame sync controller
// assumes firmware drives the cfg_ and fw_ inputs from clk_sys logic
`include "reset_standby_consts.svh"
module reset_standby_frame_sync
    import reset_standby_pkg::*;
#(
    parameter int BLACK_FIELDS = `BLACK_FIELDS_DEFAULT,
    parameter int DATA_W = 16
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic standby_pin,
    input wire logic frame_sync_pin,
    input wire logic soft_reset_write,
    input wire logic [`STRAP_WIDTH-1:0] gpio_in,
    input wire logic cfg_interlaced,
    input wire logic cfg_continuous,
    input wire logic cfg_parallel_used,
    input wire logic cfg_serial_used,
    input wire logic cfg_trigger_used,
    input wire logic fw_stream,
    input wire logic fw_soft_standby,
    input wire logic fw_release_sensor,
    input wire logic [DATA_W-1:0] pixel_data,
    output logic frame_valid_out,
    output logic line_valid_out,
    output logic pixel_clock_out,
    output logic [DATA_W-1:0] data_out,
    output logic video_oe,
    output logic trigger_out,
    output logic trigger_oe,
    output logic sensor_reset_n,
    output logic serial_lane_enable,
    output logic [`STRAP_WIDTH-1:0] gpio_oe,
    output logic [`STRAP_WIDTH-1:0] strap_value,
    output logic in_standby
);
    logic [6:0] pins_async;
    pin_sync_if sync ();
    power_state_t state;
    power_state_t next_state;
    resync_state_t rs;
    resync_state_t next_rs;
    logic [`CNT_W-1:0] field_cnt;
    logic [`CNT_W-1:0] next_field_cnt;
    logic [1:0] sb_frames;
    logic [1:0] next_sb_frames;
    logic shot_armed;
    logic next_shot_armed;
    logic free_run;
    logic next_free_run;
    logic strap_taken;
    logic next_strap_taken;
    logic [`STRAP_WIDTH-1:0] next_strap;
    logic timer_run;
    logic timer_restart;
    logic fv;
    logic lv;
    logic frame_end;
    logic progressive_trig;
    logic pclk_div;
    logic video_on;
    logic trig_on;
    logic mode_interlaced;
    logic next_mode_interlaced;
    logic mode_continuous;
    logic next_mode_continuous;

    initial
    begin
        if (BLACK_FIELDS < 1 || DATA_W < 1)
            $error("reset_standby_frame_sync parameters invalid");
    end

    assign pins_async = {gpio_in, soft_reset_write, frame_sync_pin, standby_pin};

    pin_sync #(.NUM(7)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins_async(pins_async),
        .sync(sync)
    );

    // scan and trigger modes latched only outside streaming, so a change
    // in mid-stream cannot tear a frame; firmware sets them beforehand
    always_comb
    begin
        next_mode_interlaced = mode_interlaced;
        next_mode_continuous = mode_continuous;
        if (state != st_streaming)
        begin
            next_mode_interlaced = cfg_interlaced;
            next_mode_continuous = cfg_continuous;
        end
    end

    // trigger pulse only counts in progressive mode
    assign progressive_trig = !mode_interlaced && sync.sync_rise;

    // timer runs while streaming and not held by resync or one-shot idle
    always_comb
    begin
        timer_run = (state == st_streaming) && (rs != rs_stopped);
        if (!mode_interlaced)
            timer_run = (state == st_streaming) && (shot_armed || free_run);
        // only the fall that ends a stop realigns; falls in black are ignored
        timer_restart = progressive_trig
            || (mode_interlaced && sync.sync_fall && (rs == rs_stopped));
    end

    frame_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(timer_run),
        .restart(timer_restart),
        .fv(fv),
        .lv(lv),
        .frame_end(frame_end)
    );

    // power state: standby pin and soft reset override firmware
    always_comb
    begin
        next_state = state;
        next_sb_frames = sb_frames;
        unique case (state)
            st_reset:
                next_state = st_default;
            st_default:
                if (strap_taken)
                    next_state = st_idle;
            st_idle, st_streaming, st_soft_standby:
            begin
                if (fw_soft_standby)
                    next_state = st_soft_standby;
                else
                    next_state = fw_stream ? st_streaming : st_idle;
                next_sb_frames = '0;
                if (sync.standby)
                    next_state = st_standby_entry;
            end
            st_standby_entry:
            begin
                // timer_run is low outside st_streaming, so hard standby follows at once with no frame end
                if (frame_end)
                    next_sb_frames = sb_frames + 1'b1;
                if (!timer_run || next_sb_frames == 2'(`STANDBY_MAX_FRAMES - 1))
                    next_state = st_hard_standby;
            end
            st_hard_standby:
                if (!sync.standby)
                    next_state = st_idle;
        endcase
        if (sync.soft_reset_req)
            next_state = st_reset;
    end

    // interlaced resync tracking; edges ignored until output resumes
    always_comb
    begin
        next_rs = rs;
        next_field_cnt = field_cnt;
        unique case (rs)
            rs_normal, rs_resynced:
            begin
                next_rs = rs_normal;
                if (mode_interlaced && sync.sync_rise)
                    next_rs = rs_stopped;
            end
            rs_stopped:
                if (sync.sync_fall)
                begin
                    next_rs = rs_black;
                    next_field_cnt = '0;
                end
            rs_black:
                if (frame_end)
                begin
                    next_field_cnt = field_cnt + 1'b1;
                    if (next_field_cnt == `CNT_W'(BLACK_FIELDS))
                        next_rs = rs_resynced;
                end
        endcase
        if (!mode_interlaced)
            next_rs = rs_normal;
    end

    // progressive one-shot and continuous trigger state
    always_comb
    begin
        next_shot_armed = shot_armed;
        next_free_run = free_run;
        if (progressive_trig)
        begin
            next_shot_armed = !mode_continuous;
            next_free_run = mode_continuous;
        end
        else if (frame_end)
            next_shot_armed = 1'b0;
        if (state != st_streaming || mode_interlaced)
        begin
            next_shot_armed = 1'b0;
            next_free_run = 1'b0;
        end
    end

    // strap capture once after reset release, never under reset itself
    always_comb
    begin
        next_strap_taken = strap_taken;
        next_strap = strap_value;
        if (state == st_default && !strap_taken)
        begin
            next_strap_taken = 1'b1;
            next_strap = sync.strap;
        end
        if (state == st_reset)
            next_strap_taken = 1'b0;
    end

    assign video_on = cfg_parallel_used && (state != st_reset) && (state != st_default);
    assign trig_on = cfg_trigger_used && (state != st_reset) && (state != st_default);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= st_reset;
            rs <= rs_normal;
            field_cnt <= '0;
            sb_frames <= '0;
            shot_armed <= 1'b0;
            free_run <= 1'b0;
            strap_taken <= 1'b0;
            strap_value <= '0;
            mode_interlaced <= 1'b0;
            mode_continuous <= 1'b0;
            pclk_div <= 1'b0;
            frame_valid_out <= 1'b0;
            line_valid_out <= 1'b0;
            pixel_clock_out <= 1'b0;
            data_out <= '0;
            video_oe <= 1'b0;
            trigger_out <= 1'b0;
            trigger_oe <= 1'b0;
            sensor_reset_n <= 1'b0;
            serial_lane_enable <= 1'b0;
            gpio_oe <= '0;
            in_standby <= 1'b0;
        end
        else
        begin
            state <= next_state;
            rs <= next_rs;
            field_cnt <= next_field_cnt;
            sb_frames <= next_sb_frames;
            shot_armed <= next_shot_armed;
            free_run <= next_free_run;
            strap_taken <= next_strap_taken;
            strap_value <= next_strap;
            mode_interlaced <= next_mode_interlaced;
            mode_continuous <= next_mode_continuous;
            pclk_div <= video_on ? ~pclk_div : 1'b0;
            frame_valid_out <= fv && video_on;
            line_valid_out <= lv && video_on;
            pixel_clock_out <= pclk_div;
            // black fields during resync, data otherwise
            data_out <= (lv && video_on && rs != rs_black) ? pixel_data : '0;
            video_oe <= video_on;
            trigger_out <= trig_on && progressive_trig;
            trigger_oe <= trig_on;
            // sensor held in reset until firmware releases it; hard and soft standby release it too
            if (state == st_reset || state == st_default)
                sensor_reset_n <= 1'b0;
            else if (state == st_hard_standby || state == st_soft_standby)
                sensor_reset_n <= 1'b1;
            else
                sensor_reset_n <= fw_release_sensor;
            serial_lane_enable <= cfg_serial_used && (state != st_reset)
                && (state != st_default);
            gpio_oe <= '0;
            in_standby <= (state == st_hard_standby);
        end
    end
endmodule // reset_standby_frame_sync

/* hdl/reset_standby_consts.svh */
// constants for the reset, standby and frame sync controller
// included by the top, pin_sync and frame_timer design files; definitions only
`ifndef RESET_STANDBY_CONSTS_SVH
`define RESET_STANDBY_CONSTS_SVH

`define CLK_PERIOD_NS 25
`define REF_HOLD_CYCLES 10
`define RESET_MIN_CYCLES 50
`define FIRST_SERIAL_CYCLES 100
`define STANDBY_MAX_FRAMES 2
`define ALIGN_MAX_PIXCLK 5
`define STRAP_LSB 2
`define STRAP_WIDTH 4
`define BLACK_FIELDS_DEFAULT 4
`define CNT_W 16

`endif

/* hdl/reset_standby_pkg.sv */
// types shared by the reset, standby and frame sync controller
// no assumptions beyond a SystemVerilog compiler
package reset_standby_pkg;
    typedef enum logic [2:0] {
        st_reset,
        st_default,
        st_idle,
        st_streaming,
        st_standby_entry,
        st_hard_standby,
        st_soft_standby
    } power_state_t;

    typedef enum logic [1:0] {
        rs_normal,
        rs_stopped,
        rs_black,
        rs_resynced
    } resync_state_t;
endpackage

/* hdl/pin_sync_if.sv */
`timescale 1ns/1ps
// carries synchronised pin levels and their edges to the control logic
// driven by pin_sync on the clk_sys domain
interface pin_sync_if;
    logic standby;
    logic frame_sync;
    logic sync_rise;
    logic sync_fall;
    logic soft_reset_req;
    logic [3:0] strap;
    modport producer (output standby, frame_sync, sync_rise, sync_fall, soft_reset_req, strap);
    modport consumer (input standby, frame_sync, sync_rise, sync_fall, soft_reset_req, strap);
endinterface

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
// two-flop synchronisers for the asynchronous control pins, plus edge detect
// assumes all inputs arrive from outside the clk_sys domain
`include "reset_standby_consts.svh"
module pin_sync
    import reset_standby_pkg::*;
#(
    parameter int NUM = 7
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [NUM-1:0] pins_async,
    pin_sync_if.producer sync
);
    logic [NUM-1:0] stage1;
    logic [NUM-1:0] stage2;
    logic [NUM-1:0] stage3;
    logic [NUM-1:0] next_stage3;

    initial
    begin
        if (NUM != 7)
            $error("pin_sync expects 7 pins");
    end

    // edges are taken between stage2 and stage3, never from stage1
    always_comb
    begin
        next_stage3 = stage2;
    end

    // synchroniser flops carry no reset, so the straps have settled in
    // stage2 by the time reset lifts and the capture sees real levels
    always_ff @(posedge clk_sys)
    begin
        stage1 <= pins_async;
        stage2 <= stage1;
    end

    // edge history reset to the idle pin level, so no false edge follows
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stage3 <= '0;
        else
            stage3 <= next_stage3;
    end

    assign sync.standby = stage2[0];
    assign sync.frame_sync = stage2[1];
    assign sync.sync_rise = stage2[1] & ~stage3[1];
    assign sync.sync_fall = ~stage2[1] & stage3[1];
    assign sync.soft_reset_req = stage2[2] & ~stage3[2];
    assign sync.strap = stage2[6:3];
endmodule // pin_sync

/* hdl/frame_timer.sv */
`timescale 1ns/1ps
// free-running frame and line timing for the parallel video output
// assumes the enable comes from the control state on the same clock
`include "reset_standby_consts.svh"
module frame_timer
#(
    parameter int LINE_LEN = 16,
    parameter int LINE_ACT = 12,
    parameter int FRAME_LINES = 8,
    parameter int FRAME_ACT = 6
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    output logic fv,
    output logic lv,
    output logic frame_end
);
    logic [`CNT_W-1:0] pix;
    logic [`CNT_W-1:0] line;
    logic [`CNT_W-1:0] next_pix;
    logic [`CNT_W-1:0] next_line;

    initial
    begin
        if (LINE_ACT >= LINE_LEN || FRAME_ACT >= FRAME_LINES || LINE_LEN < 2)
            $error("frame_timer geometry invalid");
    end

    // pixel and line counters; restart wins so triggered frames align
    always_comb
    begin
        next_pix = pix;
        next_line = line;
        if (restart || !run)
        begin
            next_pix = '0;
            next_line = '0;
        end
        else if (pix == `CNT_W'(LINE_LEN - 1))
        begin
            next_pix = '0;
            next_line = (line == `CNT_W'(FRAME_LINES - 1)) ? '0 : line + 1'b1;
        end
        else
            next_pix = pix + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pix <= '0;
            line <= '0;
        end
        else
        begin
            pix <= next_pix;
            line <= next_line;
        end
    end

    assign fv = run && (line < `CNT_W'(FRAME_ACT));
    assign lv = fv && (pix < `CNT_W'(LINE_ACT));
    assign frame_end = run && (pix == `CNT_W'(LINE_LEN - 1))
        && (line == `CNT_W'(FRAME_LINES - 1));
endmodule // frame_timer

/* sim/host_ctrl_model.sv */
`timescale 1ns/1ps
// behavioural host: drives hard reset, standby, frame sync and soft reset write
// assumes the bench supplies clk_sys and calls one task at a time
module host_ctrl_model
(
    input wire logic clk_sys,
    output logic rst_n,
    output logic standby_pin,
    output logic frame_sync_pin,
    output logic soft_reset_write
);
    // known levels from time zero, reset asserted
    initial
    begin
        rst_n = 1'h0;
        standby_pin = 1'h0;
        frame_sync_pin = 1'h0;
        soft_reset_write = 1'h0;
    end

    // clock never stops here, so the edges around the pulse are covered
    task automatic hard_reset();
        @(posedge clk_sys);
        rst_n <= 1'h0;
        repeat (50) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (100) @(posedge clk_sys);
    endtask

    // frame sync level, held by the caller as long as it likes
    task automatic drive_sync(input logic v);
        @(posedge clk_sys);
        frame_sync_pin <= v;
    endtask

    // clock kept 10 cycles after a standby change
    task automatic drive_standby(input logic v);
        @(posedge clk_sys);
        standby_pin <= v;
        repeat (10) @(posedge clk_sys);
    endtask

    // serial write to the soft reset register, seen as one rising edge
    task automatic soft_reset();
        @(posedge clk_sys);
        soft_reset_write <= 1'h1;
        repeat (3) @(posedge clk_sys);
        soft_reset_write <= 1'h0;
        repeat (100) @(posedge clk_sys);
    endtask
endmodule // host_ctrl_model

/* sim/reset_standby_frame_sync_properties.sv */
`timescale 1ns/1ps
// port assertions for the reset, standby and frame sync controller
// bound to every instance; one clock domain, clk_sys
`include "reset_standby_consts.svh"
module reset_standby_frame_sync_properties
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic standby_pin,
    input wire logic cfg_interlaced,
    input wire logic cfg_trigger_used,
    input wire logic cfg_parallel_used,
    input wire logic cfg_serial_used,
    input wire logic frame_valid_out,
    input wire logic video_oe,
    input wire logic trigger_out,
    input wire logic trigger_oe,
    input wire logic sensor_reset_n,
    input wire logic serial_lane_enable,
    input wire logic [`STRAP_WIDTH-1:0] gpio_oe,
    input wire logic in_standby
);
    logic [2:0] since_rel;

    // edges since hard reset release; zero means values still from reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            since_rel <= 3'h0;
        else if (since_rel != 3'h7)
            since_rel <= since_rel + 3'h1;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_reset_outputs_off: assert property (since_rel == 3'h0 |->
        !video_oe && !trigger_oe && !trigger_out && !sensor_reset_n && !serial_lane_enable)
        else $error("output driven while in reset");
    a_gpio_tristate: assert property (gpio_oe == 4'h0)
        else $error("strap pin output enable set");
    a_trigger_one_cycle: assert property (trigger_out |=> !trigger_out)
        else $error("trigger pulse longer than one cycle");
    a_trigger_driven: assert property (trigger_out |->
        trigger_oe && cfg_trigger_used && !cfg_interlaced)
        else $error("trigger pulse without driven progressive trigger");
    a_standby_sensor: assert property (in_standby |-> sensor_reset_n)
        else $error("sensor held in reset during standby");
    a_serial_unused: assert property (!cfg_serial_used [*2] |-> !serial_lane_enable)
        else $error("serial lanes enabled while unused");
    a_video_unused: assert property (!cfg_parallel_used [*2] |-> !video_oe)
        else $error("video pins driven while unused");
    a_standby_entry: assert property ($rose(standby_pin) |-> ##[1:300] in_standby)
        else $error("standby entry took longer than two frames");
    a_standby_exit: assert property ($fell(standby_pin) |-> ##[1:8] !in_standby)
        else $error("standby not left after pin release");

    // main scenarios reached
    c_trigger: cover property (trigger_out);
    c_standby: cover property (in_standby);
    c_frame: cover property ($rose(frame_valid_out));
endmodule // reset_standby_frame_sync_properties

bind reset_standby_frame_sync reset_standby_frame_sync_properties chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .standby_pin(standby_pin),
    .cfg_interlaced(cfg_interlaced), .cfg_trigger_used(cfg_trigger_used),
    .cfg_parallel_used(cfg_parallel_used), .cfg_serial_used(cfg_serial_used),
    .frame_valid_out(frame_valid_out), .video_oe(video_oe), .trigger_out(trigger_out),
    .trigger_oe(trigger_oe), .sensor_reset_n(sensor_reset_n),
    .serial_lane_enable(serial_lane_enable), .gpio_oe(gpio_oe), .in_standby(in_standby));

/* sim/tb_reset_standby_frame_sync.sv */
`timescale 1ns/1ps
// self-checking bench for reset_standby_frame_sync
// host_ctrl_model drives the pins; firmware inputs come from here
`include "reset_standby_consts.svh"
module tb_reset_standby_frame_sync;
    logic clk_sys = 1'h0;
    logic rst_n, standby_pin, frame_sync_pin, soft_reset_write;
    logic cfg_interlaced = 1'h0;
    logic cfg_continuous = 1'h0;
    logic cfg_parallel_used = 1'h1;
    logic cfg_serial_used = 1'h0;
    logic cfg_trigger_used = 1'h1;
    logic fw_stream = 1'h0;
    logic fw_release_sensor = 1'h0;
    logic fw_soft_standby = 1'h0;
    logic fv, lv, pclk, video_oe, trig, trig_oe, sens_n, lanes, stby;
    logic [15:0] dout;
    logic [3:0] gpio_oe, strap;
    int miscompares = 0;
    int compares = 0;

    always #12.5 clk_sys = ~clk_sys;

    host_ctrl_model host (.clk_sys(clk_sys), .rst_n(rst_n), .standby_pin(standby_pin),
        .frame_sync_pin(frame_sync_pin), .soft_reset_write(soft_reset_write));

    reset_standby_frame_sync uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .standby_pin(standby_pin), .frame_sync_pin(frame_sync_pin),
        .soft_reset_write(soft_reset_write), .gpio_in(4'hA),
        .cfg_interlaced(cfg_interlaced), .cfg_continuous(cfg_continuous),
        .cfg_parallel_used(cfg_parallel_used), .cfg_serial_used(cfg_serial_used),
        .cfg_trigger_used(cfg_trigger_used), .fw_stream(fw_stream),
        .fw_soft_standby(fw_soft_standby), .fw_release_sensor(fw_release_sensor),
        .pixel_data(16'h5A5A), .frame_valid_out(fv), .line_valid_out(lv),
        .pixel_clock_out(pclk), .data_out(dout), .video_oe(video_oe), .trigger_out(trig),
        .trigger_oe(trig_oe), .sensor_reset_n(sens_n), .serial_lane_enable(lanes),
        .gpio_oe(gpio_oe), .strap_value(strap), .in_standby(stby));

    task automatic check_level(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // four-state compare, so an unknown result never passes
    task automatic check_count(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        check_level(got === exp, 1'h1, what);
    endtask

    // sample a little after the edge so its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // a short sync pulse, counting trigger pulses and frame starts alongside it
    task automatic pulse_and_count(output int trigs, output int frames);
        logic last_fv;
        trigs = 0;
        frames = 0;
        last_fv = fv;
        fork
            begin
                host.drive_sync(1'h1);
                tick(6);
                host.drive_sync(1'h0);
            end
            repeat (420)
            begin
                tick(1);
                trigs += (trig === 1'h1);
                frames += (fv === 1'h1 && last_fv !== 1'h1);
                last_fv = fv;
            end
        join
    endtask

    // mode is only changed with streaming off
    task automatic set_mode(input logic inter, input logic cont);
        @(posedge clk_sys);
        fw_stream <= 1'h0;
        repeat (4) @(posedge clk_sys);
        cfg_interlaced <= inter;
        cfg_continuous <= cont;
        repeat (4) @(posedge clk_sys);
        fw_stream <= 1'h1;
        tick(20);
    endtask

    task automatic test_reset();
        fork
            host.hard_reset();
            begin
                tick(20);
                check_level(video_oe, 1'h0, "video driven in reset");
                check_level(trig_oe, 1'h0, "trigger driven in reset");
                check_level(sens_n, 1'h0, "sensor out of reset");
                check_level(lanes, 1'h0, "serial lanes on in reset");
            end
        join
        check_count(strap, 4'hA, "strap value");
        check_count(gpio_oe, 4'h0, "strap pins driven");
    endtask

    task automatic test_progressive();
        int t;
        int f;
        logic p;
        fw_release_sensor <= 1'h1;
        set_mode(1'h0, 1'h0);
        pulse_and_count(t, f);
        check_count(t, 1, "single-shot trigger count");
        check_count(f, 1, "single-shot frame count");
        check_level(video_oe, 1'h1, "video not driven while used");
        p = pclk;
        tick(1);
        check_level(pclk, ~p, "pixel clock not toggling");
        set_mode(1'h0, 1'h1);
        pulse_and_count(t, f);
        check_count(t, 1, "continuous trigger count");
        check_level(f > 1, 1'h1, "continuous output stopped");
    endtask

    // soft standby and the per-interface enables, while streaming
    task automatic test_config();
        @(posedge clk_sys);
        fw_release_sensor <= 1'h0;
        fw_soft_standby <= 1'h1;
        cfg_serial_used <= 1'h1;
        cfg_parallel_used <= 1'h0;
        cfg_trigger_used <= 1'h0;
        tick(3);
        check_level(sens_n, 1'h1, "sensor reset in soft standby");
        check_level(stby, 1'h0, "soft standby seen as hard");
        check_level(lanes, 1'h1, "serial lanes off while used");
        check_level(video_oe, 1'h0, "video driven while unused");
        check_level(trig_oe, 1'h0, "trigger driven while unused");
        @(posedge clk_sys);
        fw_soft_standby <= 1'h0;
        cfg_serial_used <= 1'h0;
        cfg_parallel_used <= 1'h1;
        cfg_trigger_used <= 1'h1;
        tick(3);
        check_level(sens_n, 1'h0, "sensor released without firmware");
        check_level(lanes, 1'h0, "serial lanes on while unused");
        check_level(video_oe, 1'h1, "video off while used again");
        check_level(trig_oe, 1'h1, "trigger not driven while used");
    endtask

    task automatic test_standby();
        int n;
        host.drive_standby(1'h1);
        for (n = 0; n < 300 && stby !== 1'h1; n++)
            tick(1);
        check_level(stby, 1'h1, "standby not entered");
        check_level(sens_n, 1'h1, "sensor reset in standby");
        host.drive_standby(1'h0);
        tick(1);
        check_level(stby, 1'h0, "standby not left");
        check_level(sens_n, 1'h0, "sensor released after standby");
        @(posedge clk_sys);
        fw_release_sensor <= 1'h1;
    endtask

    task automatic test_soft_reset();
        fork
            host.soft_reset();
            begin
                tick(6);
                check_level(sens_n, 1'h0, "sensor not reset by soft reset");
                check_level(trig_oe, 1'h0, "trigger driven after soft reset");
            end
        join
        check_level(sens_n, 1'h1, "sensor not released after soft reset");
        check_count(strap, 4'hA, "strap not recaptured");
    endtask

    task automatic test_interlaced();
        int t;
        int n;
        t = 0;
        set_mode(1'h1, 1'h0);
        tick(200);
        host.drive_sync(1'h1);
        repeat (15)
        begin
            tick(1);
            t += (trig === 1'h1);
        end
        check_level(fv, 1'h0, "frame not stopped by sync rise");
        check_count(t, 0, "trigger in interlaced mode");
        host.drive_sync(1'h0);
        tick(10);
        host.drive_sync(1'h1);
        tick(6);
        host.drive_sync(1'h0);
        for (n = 0; n < 20; n++)
        begin
            tick(1);
            if (lv === 1'h1)
                check_count(dout, 16'h0, "video not black during resync");
        end
        check_level(fv, 1'h1, "sync edge during resync not ignored");
        tick(600);
        for (n = 0; n < 40 && lv !== 1'h1; n++)
            tick(1);
        check_count(dout, 16'h5A5A, "video not resumed after resync");
    endtask

    task automatic report_and_stop();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog, nearly three times the expected run
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        test_reset();
        test_progressive();
        test_config();
        test_standby();
        test_soft_reset();
        test_interlaced();
        report_and_stop();
    end
endmodule // tb_reset_standby_frame_sync
